// ### rtl/fpa_pkg.sv
// Constants, register map and bus carriers for the flash prefetch accelerator.
// Assumes a single core clock domain and a flash array model outside the block.
// Operation
// - Each erasable sector spans both banks; erase is bank-transparent.
// - Each bank has two instruction holders: 128-bit line, 12-bit tag.
// - Branch trail holder keeps the line of the bank's latest miss.
// - Prefetch holder keeps the line from the block's own prefetch.
// - Each line store carries four 32-bit words.
// - One shared 128-bit data line with 13-bit tag, data cycles only.
// - A data miss fetches four words into the data line.
// - Flash busy programming stalls flash requests via the wait hold.
// - Program or erase start invalidates all latches; fetch after done.
// - Mode 0 serves everything with flash timing, no prefetch.
// - Mode 1 serves sequential code hits from latch, prefetch runs.
// - Mode 2 serves any code or data hit from latch.
// - Forced fetches on latched data mimic the full flash stall.
// - Reset leaves the mode field at zero, disabled.
// - A write changing the mode invalidates all latches.
// - Mode field bits 1:0: 00 off, 01 partial, 10 full, 11 reserved.
// - Timing field bits 2:0 sets fetch clocks 1..7, reset 7.
// - Reserved upper control bits are written zero; reads undefined.
// - Mode changes are accepted at any time.
// - After a line's last word that bank fetches its next line; here only when that code word is served from a latch.
// - A full instruction miss loads both banks' branch trail lines, except in a bank with a prefetch pending.
// - Data accesses never cause a prefetch.
`default_nettype none
package fpa_pkg;
	localparam int          ADDR_W       = 19;
	localparam int          LINE_W       = 128;
	localparam int          WORDS        = 4;
	localparam int          ITAG_W       = 12;
	localparam int          DTAG_W       = 13;
	localparam int          BANK_BIT     = 4;
	localparam logic [31:0] OFF_MODE     = 32'hE01FC000;
	localparam logic [31:0] OFF_TIMING   = 32'hE01FC004;
	localparam logic [1:0]  MODE_OFF     = 2'h0;
	localparam logic [1:0]  MODE_PART    = 2'h1;
	localparam logic [1:0]  MODE_FULL    = 2'h2;
	localparam logic [1:0]  MODE_RESET   = 2'h0;
	localparam logic [2:0]  TIMING_RESET = 3'h7;
	localparam int          CLK_MHZ      = 250;

	// Core fetch request as seen at the accelerator
	typedef struct packed {
		logic              valid;
		logic              isData;
		logic              seq;
		logic [ADDR_W-1:0] addr;
	} fpa_req_t;

	// Flash bank read request
	typedef struct packed {
		logic              start;
		logic [ADDR_W-5:0] lineAddr;
	} fpa_flash_req_t;

	typedef enum logic [1:0] {
		FPA_IDLE  = 2'b00,
		FPA_FETCH = 2'b01,
		FPA_DONE  = 2'b11
	} fpa_state_t;
endpackage
`default_nettype wire

// ### rtl/fpa_line_holder.sv
// One line holder: a 128-bit line store, a comparison tag and a valid bit.
// Assumes loads and invalidates come from the controller on the same clock.
`default_nettype none
module fpa_line_holder
	import fpa_pkg::*;
#(
	parameter int TAG_W = ITAG_W
) (
	input  wire logic              clock,
	input  wire logic              rst,
	input  wire logic              load,
	input  wire logic              inval,
	input  wire logic [TAG_W-1:0]  loadTag,
	input  wire logic [LINE_W-1:0] loadLine,
	input  wire logic [TAG_W-1:0]  lookTag,
	output logic                   hit,
	output logic [LINE_W-1:0]      line
);
	logic             valid_reg;
	logic [TAG_W-1:0] tag_reg;

	// Invalidate wins over load so stale lines never survive
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			valid_reg <= 1'b0;
		end else if (inval) begin
			valid_reg <= 1'b0;
		end else if (load) begin
			valid_reg <= 1'b1;
		end
	end

	// Line store and tag of four words
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tag_reg <= '0;
			line    <= '0;
		end else if (load) begin
			tag_reg <= loadTag;
			line    <= loadLine;
		end
	end

	assign hit = valid_reg && (tag_reg == lookTag);
endmodule
`default_nettype wire

// ### rtl/fpa_accel.sv
// Flash prefetch accelerator top: two banks, holders, mode and timing.
// Assumes a flash array returning a 128-bit line per bank after fetchLen
// clocks; flashBusy is synchronous to clock; registers use a plain port.
`default_nettype none
module fpa_accel
	import fpa_pkg::*;
#(
	parameter int TIM_W = 3
) (
	input  wire logic                clock,
	input  wire logic                rst,
	// Register port
	input  wire logic [31:0]         regAddr,
	input  wire logic [7:0]          regWdata,
	input  wire logic                regWrite,
	input  wire logic                regRead,
	output logic [7:0]               regRdata,
	// Core fetch port
	input  wire fpa_req_t            coreReq,
	output logic [31:0]              coreRdata,
	output logic                     coreReady,
	output logic                     coreWaitHold,
	// Flash array
	input  wire logic                flashBusy,
	input  wire logic                flashProgStart,
	output fpa_flash_req_t           bankReq [2],
	input  wire logic [LINE_W-1:0]   bankLine [2]
);
	logic [1:0]       mode_reg;
	logic [TIM_W-1:0] timing_reg;
	logic             inval;
	fpa_state_t       state_reg;
	logic [TIM_W-1:0] count_reg;
	fpa_req_t         pend_reg;
	logic             pendHit_reg;
	logic [31:0]      pendWord_reg;
	logic             pfPend_reg [2];
	logic [TIM_W-1:0] pfCount_reg [2];
	logic [ADDR_W-5:0] pfLine_reg [2];

	// Bank, tag and word selection from the request address
	logic             bank;
	logic [1:0]       wsel;
	logic [ITAG_W-1:0] itag;
	logic [DTAG_W-1:0] dtag;
	assign bank = coreReq.addr[BANK_BIT];
	assign wsel = coreReq.addr[3:2];
	assign itag = ITAG_W'(coreReq.addr[ADDR_W-1:BANK_BIT+1]);
	assign dtag = DTAG_W'(coreReq.addr[ADDR_W-1:BANK_BIT]);

	// Holder lookups
	logic              btHit [2];
	logic              pfHit [2];
	logic [LINE_W-1:0] btLine [2];
	logic [LINE_W-1:0] pfLineD [2];
	logic              dHit;
	logic [LINE_W-1:0] dLine;
	logic              btLoad [2];
	logic              pfLoad [2];
	logic [ITAG_W-1:0] btTag [2];
	logic [ITAG_W-1:0] pfTag [2];
	logic              dLoad;
	logic [LINE_W-1:0] fetchedLine;

	genvar b;
	generate
		for (b = 0; b < 2; b++) begin : g_bank
			// Branch trail holder per bank
			fpa_line_holder #(.TAG_W(ITAG_W)) u_bt (
				.clock   (clock),
				.rst     (rst),
				.load    (btLoad[b]),
				.inval   (inval),
				.loadTag (btTag[b]),
				.loadLine(bankLine[b]),
				.lookTag (itag),
				.hit     (btHit[b]),
				.line    (btLine[b])
			);
			// Prefetch holder per bank
			fpa_line_holder #(.TAG_W(ITAG_W)) u_pf (
				.clock   (clock),
				.rst     (rst),
				.load    (pfLoad[b]),
				.inval   (inval),
				.loadTag (pfTag[b]),
				.loadLine(bankLine[b]),
				.lookTag (itag),
				.hit     (pfHit[b]),
				.line    (pfLineD[b])
			);
		end
	endgenerate

	// Shared data holder, data cycles only
	fpa_line_holder #(.TAG_W(DTAG_W)) u_data (
		.clock   (clock),
		.rst     (rst),
		.load    (dLoad),
		.inval   (inval),
		.loadTag (DTAG_W'(pend_reg.addr[ADDR_W-1:BANK_BIT])),
		.loadLine(fetchedLine),
		.lookTag (dtag),
		.hit     (dHit),
		.line    (dLine)
	);

	// Register writes; mode accepted any time, reserved bits dropped
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			mode_reg   <= MODE_RESET;
			timing_reg <= TIMING_RESET;
		end else if (regWrite) begin
			if (regAddr == OFF_MODE) begin
				mode_reg <= regWdata[1:0];
			end else if (regAddr == OFF_TIMING) begin
				timing_reg <= regWdata[TIM_W-1:0];
			end
		end
	end

	// Register reads, upper bits read zero; unmapped reads zero
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			regRdata <= '0;
		end else if (regRead) begin
			if (regAddr == OFF_MODE) begin
				regRdata <= {6'h00, mode_reg};
			end else if (regAddr == OFF_TIMING) begin
				regRdata <= {5'h00, timing_reg};
			end else begin
				regRdata <= '0;
			end
		end else begin
			regRdata <= '0;
		end
	end

	// Invalidate on mode change and on program or erase start
	assign inval = flashProgStart ||
		(regWrite && regAddr == OFF_MODE && regWdata[1:0] != mode_reg);

	// Hit classification per mode
	logic codeHit;
	logic anyHit;
	logic serveLatch;
	logic [LINE_W-1:0] hitLine;
	assign codeHit = btHit[bank] || pfHit[bank];
	assign anyHit  = coreReq.isData ? dHit : codeHit;
	assign hitLine = coreReq.isData ? dLine :
		(pfHit[bank] ? pfLineD[bank] : btLine[bank]);
	always_comb begin
		serveLatch = 1'b0;
		case (mode_reg)
			MODE_PART: serveLatch = anyHit && !coreReq.isData && coreReq.seq;
			MODE_FULL: serveLatch = anyHit;
			default:   serveLatch = 1'b0;
		endcase
	end

	// Fetch length, reserved zero treated as one clock
	logic [TIM_W-1:0] fetchLen;
	assign fetchLen = (timing_reg == '0) ? TIM_W'(1) : timing_reg;

	logic reqTaken;
	assign reqTaken = coreReq.valid && state_reg == FPA_IDLE && !flashBusy;

	// Prefetch start: last word of a code line served from a latch, so the
	// bank is free; a later demand fetch can still restart that bank while it is pending
	logic              pfBegin [2];
	logic [ADDR_W-5:0] pfNext;
	logic [ADDR_W-5:0] reqLine;
	logic [ADDR_W-5:0] pairLine;
	assign pfNext   = (ADDR_W-4)'(coreReq.addr[ADDR_W-1:4] + 2);
	assign reqLine  = (ADDR_W-4)'(coreReq.addr[ADDR_W-1:4]);
	assign pairLine = (ADDR_W-4)'(coreReq.addr[ADDR_W-1:4] + 1);
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			pfBegin[i] = reqTaken && serveLatch && !coreReq.isData &&
				mode_reg != MODE_OFF && bank == 1'(i) && wsel == 2'h3 &&
				!pfPend_reg[i] && !inval;
		end
	end

	// Fetch sequencer: stall while flash busy, count fetch clocks
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_reg    <= FPA_IDLE;
			count_reg    <= '0;
			pend_reg     <= '0;
			pendHit_reg  <= 1'b0;
			pendWord_reg <= '0;
		end else begin
			case (state_reg)
				FPA_IDLE: begin
					if (reqTaken && !serveLatch) begin
						state_reg    <= FPA_FETCH;
						count_reg    <= fetchLen;
						pend_reg     <= coreReq;
						pendHit_reg  <= anyHit;
						pendWord_reg <= hitLine[wsel*32 +: 32];
					end
				end
				FPA_FETCH: begin
					if (count_reg == TIM_W'(1)) begin
						state_reg <= FPA_DONE;
					end else begin
						count_reg <= count_reg - TIM_W'(1);
					end
				end
				default: begin
					state_reg <= FPA_IDLE;
				end
			endcase
		end
	end

	// Line from the bank addressed by the pending fetch
	assign fetchedLine = bankLine[pend_reg.addr[BANK_BIT]];

	// Holder loads at the end of a fetch
	logic fetchEnd;
	assign fetchEnd = state_reg == FPA_FETCH && count_reg == TIM_W'(1);
	assign dLoad = fetchEnd && pend_reg.isData && !pendHit_reg;
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			// Full code miss captures the lines of both banks, except a bank with a pending prefetch
			btLoad[i] = fetchEnd && !pend_reg.isData && !pendHit_reg &&
				!pfPend_reg[i];
			btTag[i]  = ITAG_W'(pend_reg.addr[ADDR_W-1:BANK_BIT+1] +
				((i == 0 && pend_reg.addr[BANK_BIT]) ? 1 : 0));
			pfLoad[i] = pfPend_reg[i] && pfCount_reg[i] == TIM_W'(1);
			pfTag[i]  = ITAG_W'(pfLine_reg[i] >> 1);
		end
	end

	// Speculative prefetch after a code line's last word
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 2; i++) begin
				pfPend_reg[i]  <= 1'b0;
				pfCount_reg[i] <= '0;
				pfLine_reg[i]  <= '0;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (inval || flashBusy) begin
					pfPend_reg[i] <= 1'b0;
				end else if (pfPend_reg[i]) begin
					if (pfCount_reg[i] == TIM_W'(1)) begin
						pfPend_reg[i] <= 1'b0;
					end else begin
						pfCount_reg[i] <= pfCount_reg[i] - TIM_W'(1);
					end
				end else if (pfBegin[i]) begin
					pfPend_reg[i]  <= 1'b1;
					pfCount_reg[i] <= fetchLen;
					pfLine_reg[i]  <= pfNext;
				end
			end
		end
	end

	// Flash bank requests: demand fetch or prefetch start
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < 2; i++) begin
				bankReq[i] <= '0;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				bankReq[i].start <= (reqTaken && !serveLatch) || pfBegin[i];
				// Other bank reads the paired next line for its trail holder
				if (pfBegin[i]) begin
					bankReq[i].lineAddr <= pfNext;
				end else if (bank == 1'(i)) begin
					bankReq[i].lineAddr <= reqLine;
				end else begin
					bankReq[i].lineAddr <= pairLine;
				end
			end
		end
	end

	// Core answer: hits answer next cycle, fetches fetchLen cycles after that
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			coreReady <= 1'b0;
			coreRdata <= '0;
		end else begin
			coreReady <= 1'b0;
			if (reqTaken && serveLatch) begin
				coreReady <= 1'b1;
				coreRdata <= hitLine[wsel*32 +: 32];
			end else if (fetchEnd) begin
				coreReady <= 1'b1;
				coreRdata <= pendHit_reg ? pendWord_reg :
					fetchedLine[pend_reg.addr[3:2]*32 +: 32];
			end
		end
	end

	// Wait hold: flash busy or fetch in progress stalls the core
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			coreWaitHold <= 1'b0;
		end else begin
			coreWaitHold <= (coreReq.valid && flashBusy) ||
				(reqTaken && !serveLatch) ||
				(state_reg == FPA_FETCH && count_reg != TIM_W'(1));
		end
	end
endmodule
`default_nettype wire

// ### dv/fpa_accel_assertions.sv
// Checker for the accelerator's register and core fetch ports.
// Assumes it is bound to fpa_accel and sees only its ports.
`default_nettype none
module fpa_accel_assertions
	import fpa_pkg::*;
(
	input wire logic           clock,
	input wire logic           rst,
	input wire logic [31:0]    regAddr,
	input wire logic [7:0]     regWdata,
	input wire logic           regWrite,
	input wire logic           regRead,
	input wire logic [7:0]     regRdata,
	input wire fpa_req_t       coreReq,
	input wire logic           coreReady,
	input wire logic           coreWaitHold,
	input wire logic           flashBusy,
	input wire fpa_flash_req_t bankReq [2]
);
	logic [1:0] modeReg;
	logic [2:0] timReg;
	logic       pend;
	logic       busySeen;
	logic [3:0] cnt;
	logic [3:0] readyAt;

	// Shadow copies of the two control fields
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			modeReg <= MODE_RESET;
			timReg  <= TIMING_RESET;
		end else if (regWrite && regAddr == OFF_MODE) begin
			modeReg <= regWdata[1:0];
		end else if (regWrite && regAddr == OFF_TIMING) begin
			timReg <= regWdata[2:0];
		end
	end

	// Cycles from taking a core request to its answer
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pend <= 1'b0;
			cnt  <= 4'h0;
		end else if (coreReady) begin
			pend <= 1'b0;
		end else if (pend) begin
			cnt <= (cnt == 4'hF) ? cnt : cnt + 4'h1;
		end else if (coreReq.valid && !flashBusy) begin
			pend <= 1'b1;
			cnt  <= 4'h1;
		end
	end

	// Requests that met a busy flash are left out of latency checks
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			busySeen <= 1'b0;
		end else if (coreReady) begin
			busySeen <= 1'b0;
		end else if (coreReq.valid && flashBusy) begin
			busySeen <= 1'b1;
		end
	end

	assign readyAt = (timReg == 3'h0) ? 4'h2 : {1'b0, timReg} + 4'h1;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_modeRead;
		regRead && regAddr == OFF_MODE;
	endsequence
	sequence s_timRead;
		regRead && regAddr == OFF_TIMING;
	endsequence

	a_mode_readback: assert property (s_modeRead |=>
		regRdata == {6'h00, modeReg}) else $error("mode readback wrong");
	a_timing_readback: assert property (s_timRead |=>
		regRdata == {5'h00, timReg}) else $error("timing readback wrong");
	a_ready_single: assert property (coreReady |=>
		!coreReady) else $error("core ready longer than one cycle");
	a_ready_latency: assert property (coreReady && !busySeen |->
		cnt == 4'h1 || cnt == readyAt) else $error("core answer latency");
	a_forced_timing: assert property (coreReady && !busySeen &&
		(modeReg == MODE_OFF || (modeReg == MODE_PART &&
		(coreReq.isData || !coreReq.seq))) |-> cnt == readyAt)
		else $error("forced fetch timing wrong");
	a_busy_waits: assert property (coreReq.valid && flashBusy &&
		!coreReady |=> coreWaitHold) else $error("no wait while busy");
	a_busy_no_ready: assert property ((!pend && coreReq.valid &&
		flashBusy) [*3] |-> !coreReady) else $error("answer while busy");
	a_off_no_prefetch: assert property (modeReg == MODE_OFF &&
		(bankReq[0].start || bankReq[1].start) |-> pend)
		else $error("prefetch while disabled");
endmodule

bind fpa_accel fpa_accel_assertions fpa_accel_assertions_inst (
	.clock(clock), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
	.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
	.coreReq(coreReq), .coreReady(coreReady), .coreWaitHold(coreWaitHold),
	.flashBusy(flashBusy), .bankReq(bankReq));
`default_nettype wire

// ### dv/fpa_flash_model.sv
// Two-bank flash array model answering line reads from the accelerator.
// Assumes the line is sampled by the accelerator after its fetch time.
`default_nettype none
module fpa_flash_model
	import fpa_pkg::*;
(
	input wire logic           clock,
	input wire logic           rst,
	input wire fpa_flash_req_t bankReq [2],
	output logic [LINE_W-1:0]  bankLine [2]
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [ADDR_W-5:0] lineReg  [2];
	logic              validReg [2];

	for (genvar b = 0; b < 2; b++) begin : g_bank
		// Each bank latches the line address when a read starts
		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				validReg[b] <= 1'b0;
			end else if (bankReq[b].start) begin
				lineReg[b]  <= bankReq[b].lineAddr;
				validReg[b] <= 1'b1;
			end
		end
		// Line shows from the start cycle on, then holds
		logic [ADDR_W-5:0] curLine;
		assign curLine = bankReq[b].start ? bankReq[b].lineAddr : lineReg[b];
		// Word w holds the line address, its inverse and w
		always_comb begin
			bankLine[b] = '1;
			for (int w = 0; w < WORDS; w++) begin
				if (validReg[b] || bankReq[b].start) begin
					bankLine[b][32*w +: 32] = {curLine, ~curLine, 2'(w)};
				end
			end
		end
	end
endmodule
`default_nettype wire

// ### dv/fpa_accel_test.sv
// Testbench for the accelerator: register and core fetch sequences.
// Assumes the flash model's address-derived line pattern.
`default_nettype none
module fpa_accel_test
	import fpa_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic                clock, rst, regWrite, regRead, coreReady;
	logic                coreWaitHold, flashBusy, flashProgStart;
	logic [31:0]         regAddr, coreRdata;
	logic [7:0]          regWdata, regRdata;
	fpa_req_t            coreReq;
	fpa_flash_req_t      bankReq [2];
	logic [LINE_W-1:0]   bankLine [2];
	int                  mismatches, num_checks, lastLat;

	fpa_accel fpa_accel_inst (.clock(clock), .rst(rst), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .coreReq(coreReq), .coreRdata(coreRdata),
		.coreReady(coreReady), .coreWaitHold(coreWaitHold),
		.flashBusy(flashBusy), .flashProgStart(flashProgStart),
		.bankReq(bankReq), .bankLine(bankLine));
	fpa_flash_model fpa_flash_model_inst (.clock(clock), .rst(rst),
		.bankReq(bankReq), .bankLine(bankLine));

	// Core clock, 4 ns period
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [31:0] a, input logic [7:0] d);
		@(posedge clock);
		regAddr  <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask

	task automatic reg_rd(input logic [31:0] a, input logic [7:0] e);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1;
		chk({24'h0, regRdata}, {24'h0, e});
	endtask

	// Holds a request until ready, checks word and latency (0 skips it)
	task automatic core(input logic d, s, input logic [18:0] a, input int lat);
		int n;
		n = 0;
		@(posedge clock);
		coreReq <= '{valid: 1'b1, isData: d, seq: s, addr: a};
		do begin
			@(posedge clock);
			#1;
			n++;
		end while (coreReady !== 1'b1 && n < 40);
		coreReq.valid <= 1'b0;
		lastLat = n;
		if (coreReady !== 1'b1) begin
			mismatches++;
			report_and_stop();
		end
		chk(coreRdata, {a[18:4], ~a[18:4], a[3:2]});
		if (lat > 0) chk(32'(lastLat), 32'(lat));
	endtask

	initial begin
		rst = 1'b1;
		{regAddr, regWdata, regWrite, regRead} = '0;
		{coreReq, flashBusy, flashProgStart} = '0;
		mismatches = 0;
		num_checks = 0;
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		reg_rd(OFF_MODE, 8'h00);
		reg_rd(OFF_TIMING, 8'h07);
		reg_rd(32'hE01FC008, 8'h00);
		reg_wr(OFF_TIMING, 8'h05);
		reg_rd(OFF_TIMING, 8'h05);
		for (int t = 1; t < 8; t++) begin
			reg_wr(OFF_TIMING, 8'(t));
			core(1'b1, 1'b0, 19'h00400, t + 1);
			core(1'b1, 1'b1, 19'h00404, t + 1);
			core(1'b0, 1'b1, 19'h00408, t + 1);
		end
		reg_wr(OFF_TIMING, 8'h03);
		reg_wr(OFF_MODE, 8'h01);
		reg_rd(OFF_MODE, 8'h01);
		core(1'b0, 1'b0, 19'h00200, 4);
		core(1'b0, 1'b1, 19'h00204, 1);
		core(1'b0, 1'b0, 19'h00208, 4);
		core(1'b1, 1'b0, 19'h00404, 4);
		reg_wr(OFF_MODE, 8'h02);
		core(1'b0, 1'b0, 19'h00208, 4);
		core(1'b0, 1'b0, 19'h00200, 1);
		core(1'b0, 1'b1, 19'h00210, 1);
		core(1'b1, 1'b0, 19'h00404, 4);
		core(1'b1, 1'b0, 19'h0040C, 1);
		// Programming starts with the data line held
		@(posedge clock);
		flashBusy      <= 1'b1;
		flashProgStart <= 1'b1;
		@(posedge clock);
		flashProgStart <= 1'b0;
		fork
			begin
				repeat (6) @(posedge clock);
				#1;
				chk({31'h0, coreWaitHold}, 32'h1);
				repeat (6) @(posedge clock);
				flashBusy <= 1'b0;
			end
			core(1'b1, 1'b0, 19'h00404, 0);
		join
		chk(32'(lastLat >= 15), 32'h1);
		core(1'b1, 1'b1, 19'h00408, 1);
		report_and_stop();
	end
endmodule
`default_nettype wire
